// ===== fsp_defs.svh
// Constants for the formatted serial print port.
// Assumes inclusion by bare name from the design file.
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH
// ****************************************
// Clock and timing
// ****************************************
`define FSP_CLK_HZ      25000000
`define FSP_TICK_S      1
`define FSP_BAUD_MIN    300
`define FSP_BAUD_DEF    3'h5
`define FSP_INTV_MAX    15'h7080
`define FSP_BURST_MAX   3'h4
// ****************************************
// Configuration encodings
// ****************************************
`define FSP_MODE_TALK   2'h0
`define FSP_MODE_DUPLEX 2'h1
`define FSP_MODE_LISTEN 2'h2
`define FSP_MODE_OFF    2'h3
`define FSP_PAR_NONE    2'h0
`define FSP_PAR_EVEN    2'h1
`define FSP_PAR_ODD     2'h2
`define FSP_FLOW_NONE   2'h0
`define FSP_FLOW_SW     2'h1
`define FSP_FLOW_HW     2'h2
`define FSP_MDM_REMOTE  2'h0
`define FSP_MDM_OFF     2'h1
`define FSP_MDM_PASS    2'h2
`define FSP_MDM_INIT    2'h3
// ****************************************
// Characters, string defaults and FIFO size
// ****************************************
`define FSP_CH_AT       8'h40
`define FSP_CH_E        8'h45
`define FSP_CH_W        8'h57
`define FSP_CH_ONE      8'h31
`define FSP_CH_END      8'hFF
`define FSP_CH_LF       8'h0A
`define FSP_CH_XON      8'h11
`define FSP_CH_XOFF     8'h13
`define FSP_CH_D0       8'h30
`define FSP_CH_D9       8'h39
`define FSP_PRE_LEN_DEF 3'h0
`define FSP_SUF_LEN_DEF 3'h1
`define FSP_SUF_DEF     32'h0000000A
`define FSP_STR_MAX     3'h4
`define FSP_WGT_LAST    3'h7
`define FSP_FIFO_W      8
`define FSP_FIFO_D      16
`endif

// ===== fsp_pkg.sv
// Types shared by the formatted serial print port.
// Assumes nothing of its surroundings.
package fsp_pkg;
   // Print-string interpreter states.
   typedef enum logic [3:0] {
      SQ_IDLE, SQ_PRE, SQ_SCAN, SQ_CMD, SQ_WDIG, SQ_WGT, SQ_SKIP, SQ_SUF, SQ_WAIT
   } fsp_seq_t;
endpackage : fsp_pkg

// ===== fsp_top.sv
// Formatted serial print port: interpreter, FIFO, UART transmitter and receiver.
// Assumes one 25 MHz clock, synchronous inputs and a synchronous high reset.
`include "fsp_defs.svh"

// ****************************************
// Byte FIFO between interpreter and transmitter
// ****************************************
module fsp_fifo #(
   parameter int W  = `FSP_FIFO_W,
   parameter int D  = `FSP_FIFO_D,
   parameter int AW = $clog2(D)
) (
   input  wire logic         i_clock,
   input  wire logic         i_sys_rst,
   input  wire logic [W-1:0] i_in_data,
   input  wire logic         i_in_valid,
   output logic              o_in_ready,
   output logic [W-1:0]      o_out_data,
   output logic              o_out_valid,
   input  wire logic         i_out_ready,
   output logic [AW:0]       o_count
);
   logic [W-1:0] mem [D];      // Storage words.
   logic [AW-1:0] wr_q, rd_q;  // Write and read pointers.
   logic [AW:0]   cnt_q;       // Words held.
   wire push = i_in_valid & o_in_ready;
   wire pop  = o_out_valid & i_out_ready;
   assign o_in_ready  = (cnt_q != (AW+1)'(D));  // Full only at D words; count is AW+1 bits.
   assign o_out_valid = (cnt_q != '0);
   assign o_out_data  = mem[rd_q];
   assign o_count     = cnt_q;
   // Pointers and fill count move on accepted pushes and pops.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop) rd_q <= rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   // Data written without reset.
   always_ff @(posedge i_clock) begin
      if (push) mem[wr_q] <= i_in_data;
   end
endmodule : fsp_fifo

// ****************************************
// Top level of the print port
// ****************************************
module fsp_top import fsp_pkg::*; #(
   parameter int CLK_HZ = `FSP_CLK_HZ
) (
   input  wire logic        i_clock,
   input  wire logic        i_sys_rst,
   input  wire logic        i_cfg_wr,
   input  wire logic        i_load_defaults,
   input  wire logic [2:0]  i_baud_sel,
   input  wire logic        i_two_stop,
   input  wire logic        i_seven_bits,
   input  wire logic [1:0]  i_parity,
   input  wire logic [2:0]  i_prefix_len,
   input  wire logic [31:0] i_prefix_chars,
   input  wire logic [2:0]  i_suffix_len,
   input  wire logic [31:0] i_suffix_chars,
   input  wire logic        i_str_wr,
   input  wire logic [7:0]  i_str_addr,
   input  wire logic [7:0]  i_str_char,
   input  wire logic [1:0]  i_port_mode,
   input  wire logic [1:0]  i_flow,
   input  wire logic [1:0]  i_modem_mode,
   input  wire logic        i_wait_en,
   input  wire logic [7:0]  i_wait_char,
   input  wire logic        i_print_key,
   input  wire logic        i_print_lock,
   input  wire logic        i_ctl_event,
   input  wire logic        i_cts_trigger,
   input  wire logic        i_settled_only,
   input  wire logic        i_in_motion,
   input  wire logic        i_interval_on,
   input  wire logic [14:0] i_interval_sec,
   input  wire logic [63:0] i_weight_chars,
   input  wire logic [7:0]  i_modem_byte,
   input  wire logic        i_modem_valid,
   input  wire logic        i_rxd,
   input  wire logic        i_cts,
   output logic             o_txd,
   output logic             o_rts,
   output logic [7:0]       o_rx_data,
   output logic             o_rx_valid,
   output logic             o_rx_error,
   output logic             o_modem_ready,
   output logic             o_modem_on,
   output logic             o_modem_init,
   output logic             o_busy
);
   // ****************************************
   // Helper functions
   // ****************************************
   // Bit period in clocks for a rate code; rates double from the base.
   function automatic logic [16:0] baud_div(input logic [2:0] sel);
      baud_div = 17'(CLK_HZ / (`FSP_BAUD_MIN << sel));
   endfunction : baud_div
   // Built-in print string: weight in display mode, then line end.
   function automatic logic [7:0] dflt_chr(input logic [7:0] a);
      case (a)
         8'h00, 8'h03: dflt_chr = `FSP_CH_AT;
         8'h01:        dflt_chr = `FSP_CH_W;
         8'h02:        dflt_chr = `FSP_CH_ONE;
         8'h04:        dflt_chr = `FSP_CH_E;
         default:      dflt_chr = `FSP_CH_END;
      endcase
   endfunction : dflt_chr
   // True for an ASCII decimal digit.
   function automatic logic is_dig(input logic [7:0] c);
      is_dig = (c >= `FSP_CH_D0) && (c <= `FSP_CH_D9);
   endfunction : is_dig

   // ****************************************
   // Configuration registers
   // ****************************************
   logic [2:0]  baud_q;              // Rate code.
   logic        two_q, b7_q;         // Stop count and data width.
   logic [1:0]  par_q;               // Parity kind.
   logic [2:0]  pre_len_q, suf_len_q; // String lengths.
   logic [31:0] pre_q, suf_q;       // String characters, first in low byte.
   logic        dflt_q;              // Use the built-in print string.
   logic [7:0]  mem [256];           // Stored print string.
   // Defaults on reset or load, else take new settings on a write.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst | i_load_defaults) begin
         baud_q    <= `FSP_BAUD_DEF;
         two_q     <= 1'b0;
         b7_q      <= 1'b0;
         par_q     <= `FSP_PAR_NONE;
         pre_len_q <= `FSP_PRE_LEN_DEF;
         pre_q     <= '0;
         suf_len_q <= `FSP_SUF_LEN_DEF;
         suf_q     <= `FSP_SUF_DEF;
         dflt_q    <= 1'b1;
      end else begin
         if (i_cfg_wr) begin
            baud_q    <= i_baud_sel;
            two_q     <= i_two_stop;
            b7_q      <= i_seven_bits;
            par_q     <= i_parity;
            pre_len_q <= (i_prefix_len > `FSP_STR_MAX) ? `FSP_STR_MAX : i_prefix_len;
            pre_q     <= i_prefix_chars;
            suf_len_q <= (i_suffix_len > `FSP_STR_MAX) ? `FSP_STR_MAX : i_suffix_len;
            suf_q     <= i_suffix_chars;
         end
         if (i_str_wr) dflt_q <= 1'b0;
      end
   end
   // Print string storage.
   always_ff @(posedge i_clock) begin
      if (i_str_wr) mem[i_str_addr] <= i_str_char;
   end

   // ****************************************
   // Mode decode and flow gating
   // ****************************************
   wire tx_mode = (i_port_mode == `FSP_MODE_TALK) | (i_port_mode == `FSP_MODE_DUPLEX);
   wire rx_en   = (i_port_mode == `FSP_MODE_DUPLEX) | (i_port_mode == `FSP_MODE_LISTEN);
   wire pass    = (i_modem_mode == `FSP_MDM_PASS);
   wire [16:0] div = baud_div(baud_q);
   logic xoff_q;                     // Far end asked for a pause.
   wire flow_ok = (i_flow == `FSP_FLOW_SW) ? ~xoff_q :
                  (i_flow == `FSP_FLOW_HW) ? i_cts : 1'b1;
   wire wait_on = i_wait_en & (i_port_mode == `FSP_MODE_DUPLEX);

   // ****************************************
   // Triggers, interval and rate limit
   // ****************************************
   fsp_seq_t    st_q;                // Interpreter state.
   logic        cts_q;               // Last CTS level.
   logic        pend_q, rep_q;       // Pending start, repeating.
   logic [24:0] tick_q;              // Clocks into the current second.
   logic [14:0] secs_q;              // Seconds since last start.
   logic [2:0]  burst_q;             // Starts in the current second.
   wire sec_tick = (tick_q == 25'(CLK_HZ - 1));
   wire [14:0] intv = (i_interval_sec > `FSP_INTV_MAX) ? `FSP_INTV_MAX : i_interval_sec;
   wire trig = (i_print_key & ~i_print_lock)
             | i_ctl_event
             | (i_cts_trigger & i_cts & ~cts_q);
   wire due = rep_q & (secs_q >= intv);
   wire start = pend_q & (st_q == SQ_IDLE) & tx_mode & ~pass
              & (~i_settled_only | ~i_in_motion)
              & (burst_q < `FSP_BURST_MAX);
   // Pending, repeat and one-second bookkeeping.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         cts_q   <= 1'b1;                  // Starts at mark so a high CTS is no edge.
         pend_q  <= 1'b0;
         rep_q   <= 1'b0;
         tick_q  <= '0;
         secs_q  <= '0;
         burst_q <= '0;
      end else begin
         cts_q  <= i_cts;
         pend_q <= trig | due | (pend_q & ~start);
         rep_q  <= i_interval_on & ~(i_cts_trigger & ~i_cts) & (rep_q | start);
         tick_q <= sec_tick ? '0 : tick_q + 1'b1;
         if (start) secs_q <= '0;
         else if (sec_tick && secs_q != '1) secs_q <= secs_q + 1'b1;
         if (sec_tick) burst_q <= 3'(start);
         else if (start) burst_q <= burst_q + 1'b1;
      end
   end

   // ****************************************
   // Print-string interpreter
   // ****************************************
   logic [7:0] ptr_q;                // String read position.
   logic [2:0] sub_q;                // Position within a sub-string.
   logic       hit_q;                // Wait character seen.
   logic [7:0] fin_data, fout_data;
   logic       fin_rdy, fout_vld, fout_rdy;
   logic [4:0] fcnt;
   wire [7:0] cur = dflt_q ? dflt_chr(ptr_q) : mem[ptr_q];
   wire [7:0] pre_b = pre_q[{sub_q[1:0], 3'h0} +: 8];
   wire [7:0] suf_b = suf_q[{sub_q[1:0], 3'h0} +: 8];
   wire [7:0] wgt_b = i_weight_chars[{~sub_q, 3'h0} +: 8];
   wire emit_req = ((st_q == SQ_PRE) & (sub_q != pre_len_q))
                 | ((st_q == SQ_SCAN) & (cur != `FSP_CH_END) & (cur != `FSP_CH_AT))
                 | ((st_q == SQ_CMD) & (cur == `FSP_CH_AT))
                 | (st_q == SQ_WGT)
                 | ((st_q == SQ_SUF) & (sub_q != suf_len_q));
   wire [7:0] emit_b = (st_q == SQ_PRE) ? pre_b : (st_q == SQ_SUF) ? suf_b :
                       (st_q == SQ_WGT) ? wgt_b : cur;
   wire drop = b7_q & emit_b[7];
   wire adv  = emit_req & (drop | fin_rdy);
   wire more = (cur != `FSP_CH_END);
   // Walks the string, expanding commands into output bytes.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst || !tx_mode) begin
         st_q  <= SQ_IDLE;
         ptr_q <= '0;
         sub_q <= '0;
      end else begin
         case (st_q)
            SQ_IDLE: begin
               if (start) begin
                  ptr_q <= '0;
                  sub_q <= '0;
                  st_q  <= SQ_PRE;
               end
            end
            SQ_PRE: begin
               if (sub_q == pre_len_q) st_q <= SQ_SCAN;
               else if (adv) sub_q <= sub_q + 1'b1;
            end
            SQ_SCAN: begin
               if (!more) st_q <= SQ_IDLE;
               else if (cur == `FSP_CH_AT) begin
                  ptr_q <= ptr_q + 1'b1;
                  st_q  <= SQ_CMD;
               end else if (adv) ptr_q <= ptr_q + 1'b1;
            end
            SQ_CMD: begin
               sub_q <= '0;
               case (cur)
                  `FSP_CH_AT: begin
                     if (adv) begin
                        ptr_q <= ptr_q + 1'b1;
                        st_q  <= SQ_SCAN;
                     end
                  end
                  `FSP_CH_E: begin
                     ptr_q <= ptr_q + 1'b1;
                     st_q  <= SQ_SUF;
                  end
                  `FSP_CH_W: begin
                     ptr_q <= ptr_q + 1'b1;
                     st_q  <= SQ_WDIG;
                  end
                  `FSP_CH_END: st_q <= SQ_IDLE;
                  default: begin
                     ptr_q <= ptr_q + 1'b1;
                     st_q  <= SQ_SKIP;
                  end
               endcase
            end
            SQ_WDIG: begin
               if (is_dig(cur)) ptr_q <= ptr_q + 1'b1;
               st_q <= SQ_WGT;
            end
            SQ_WGT: begin
               if (adv) begin
                  sub_q <= sub_q + 1'b1;
                  if (sub_q == `FSP_WGT_LAST) st_q <= SQ_SCAN;
               end
            end
            SQ_SKIP: begin
               if (is_dig(cur)) ptr_q <= ptr_q + 1'b1;
               else st_q <= SQ_SCAN;
            end
            SQ_SUF: begin
               if (sub_q == suf_len_q) begin
                  sub_q <= '0;
                  if (wait_on) st_q <= SQ_WAIT;
                  else st_q <= more ? SQ_PRE : SQ_IDLE;
               end else if (adv) sub_q <= sub_q + 1'b1;
            end
            SQ_WAIT: begin
               if (hit_q) st_q <= more ? SQ_PRE : SQ_IDLE;
            end
            default: st_q <= SQ_IDLE;
         endcase
      end
   end

   // ****************************************
   // FIFO and transmitter
   // ****************************************
   assign fin_data = pass ? i_modem_byte : emit_b;
   wire fin_vld = pass ? (i_modem_valid & o_modem_ready) : (emit_req & ~drop);
   fsp_fifo #(.W(`FSP_FIFO_W), .D(`FSP_FIFO_D)) u_fifo (
      .i_clock     (i_clock),
      .i_sys_rst   (i_sys_rst),
      .i_in_data   (fin_data),
      .i_in_valid  (fin_vld),
      .o_in_ready  (fin_rdy),
      .o_out_data  (fout_data),
      .o_out_valid (fout_vld),
      .i_out_ready (fout_rdy),
      .o_count     (fcnt)
   );
   logic        tx_busy_q;           // Frame in flight.
   logic [11:0] tx_sh_q;             // Bits still to send, LSB next.
   logic [3:0]  tx_left_q;           // Bits left in frame.
   logic [16:0] tx_cnt_q;            // Clocks left in this bit.
   wire [7:0] fd = fout_data;
   wire p_bit = (b7_q ? ^fd[6:0] : ^fd) ^ (par_q == `FSP_PAR_ODD);
   wire has_p = (par_q != `FSP_PAR_NONE);
   wire [11:0] frame = b7_q ? {3'h7, has_p ? p_bit : 1'b1, fd[6:0], 1'b0}
                            : {2'h3, has_p ? p_bit : 1'b1, fd, 1'b0};
   wire [3:0] nbits = 4'(b7_q ? 8 : 9) + 4'(has_p) + 4'(two_q) + 4'h1;
   assign fout_rdy = ~tx_busy_q & fout_vld & tx_mode & flow_ok;
   // Shifts one frame out, LSB first, start bit low.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         tx_busy_q <= 1'b0;
         tx_sh_q   <= '1;
         tx_left_q <= '0;
         tx_cnt_q  <= '0;
         o_txd     <= 1'b1;
      end else if (fout_rdy) begin
         tx_busy_q <= 1'b1;
         tx_sh_q   <= frame;
         tx_left_q <= nbits;
         tx_cnt_q  <= div - 1'b1;
         o_txd     <= frame[0];
      end else if (tx_busy_q) begin
         if (tx_cnt_q != '0) tx_cnt_q <= tx_cnt_q - 1'b1;
         else if (tx_left_q == 4'h1) begin
            tx_busy_q <= 1'b0;
            o_txd     <= 1'b1;
         end else begin
            tx_sh_q   <= {1'b1, tx_sh_q[11:1]};
            tx_left_q <= tx_left_q - 1'b1;
            tx_cnt_q  <= div - 1'b1;
            o_txd     <= tx_sh_q[1];
         end
      end
   end

   // ****************************************
   // Receiver
   // ****************************************
   logic        rx_busy_q;           // Frame being sampled.
   logic [3:0]  rx_idx_q;            // 0 start, then data and parity, then stop.
   logic [16:0] rx_cnt_q;            // Clocks to next sample.
   logic [8:0]  rx_sh_q;             // Sampled bits.
   wire [3:0] rx_nd = 4'(b7_q ? 7 : 8) + 4'(has_p);
   wire [7:0] rx_b = b7_q ? {1'b0, rx_sh_q[6:0]} : rx_sh_q[7:0];
   wire rx_pb = b7_q ? rx_sh_q[7] : rx_sh_q[8];
   wire rx_pe = has_p & (rx_pb != ((b7_q ? ^rx_sh_q[6:0] : ^rx_sh_q[7:0])
                                   ^ (par_q == `FSP_PAR_ODD)));
   wire rx_smp = rx_busy_q & (rx_cnt_q == '0);
   wire rx_done = rx_smp & (rx_idx_q > rx_nd);
   wire rx_hit = rx_done & wait_on & (rx_b == i_wait_char);
   // Samples mid-bit after a start edge.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         rx_busy_q <= 1'b0;
         rx_idx_q  <= '0;
         rx_cnt_q  <= '0;
         rx_sh_q   <= '0;
      end else if (!rx_busy_q) begin
         rx_busy_q <= rx_en & ~i_rxd;
         rx_idx_q  <= '0;
         rx_cnt_q  <= {1'b0, div[16:1]};
      end else if (!rx_smp) rx_cnt_q <= rx_cnt_q - 1'b1;
      else begin
         rx_cnt_q <= div - 1'b1;
         rx_idx_q <= rx_idx_q + 1'b1;
         if (rx_idx_q == '0 && i_rxd) rx_busy_q <= 1'b0;
         else if (rx_idx_q != '0 && !rx_done) rx_sh_q[rx_idx_q - 1'b1] <= i_rxd;
         if (rx_done) rx_busy_q <= 1'b0;
      end
   end
   // Received byte, flow state and pacing flag; a new hit beats the clear.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_rx_data  <= '0;
         o_rx_valid <= 1'b0;
         o_rx_error <= 1'b0;
         xoff_q     <= 1'b0;
         hit_q      <= 1'b0;
      end else begin
         o_rx_valid <= rx_done;
         o_rx_error <= rx_done & (rx_pe | ~i_rxd);
         if (rx_done) o_rx_data <= rx_b;
         if (i_flow != `FSP_FLOW_SW) xoff_q <= 1'b0;
         else if (rx_done && rx_b == `FSP_CH_XOFF) xoff_q <= 1'b1;
         else if (rx_done && rx_b == `FSP_CH_XON) xoff_q <= 1'b0;
         hit_q <= rx_hit | (hit_q & ~(st_q == SQ_WAIT));
      end
   end

   // ****************************************
   // Status and modem outputs
   // ****************************************
   logic [1:0] mdm_q;                // Previous modem setting.
   // Registered status, handshake and modem controls.
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_rts         <= 1'b1;
         o_modem_ready <= 1'b0;
         o_modem_on    <= 1'b1;
         o_modem_init  <= 1'b0;
         o_busy        <= 1'b0;
         mdm_q         <= `FSP_MDM_REMOTE;
      end else begin
         o_rts         <= (i_flow != `FSP_FLOW_HW) | rx_en;
         o_modem_ready <= pass & tx_mode & (fcnt < 5'(`FSP_FIFO_D - 2));
         o_modem_on    <= (i_modem_mode != `FSP_MDM_OFF);
         o_modem_init  <= (i_modem_mode == `FSP_MDM_INIT) & (mdm_q != `FSP_MDM_INIT);
         o_busy        <= (st_q != SQ_IDLE) | pend_q | (fcnt != '0) | tx_busy_q;
         mdm_q         <= i_modem_mode;
      end
   end
endmodule : fsp_top

// ===== fsp_top_asserts.sv
// Checker watching the ports of the print port top level.
// Assumes a bit time of eight clocks, as the bench sets it.
module fsp_top_asserts (
   input wire logic       i_clock, i_sys_rst, i_print_key, i_print_lock, i_ctl_event,
   input wire logic       i_cts_trigger, i_interval_on, o_txd, o_rts, o_busy, o_rx_valid,
   input wire logic       o_modem_init, o_modem_ready,
   input wire logic [1:0] i_port_mode, i_modem_mode
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   property p_rst; disable iff (1'b0) i_sys_rst |=> o_txd && o_rts && !o_busy; endproperty
   a_rst: assert property (p_rst) else $error("port not quiet after reset");
   property p_key; i_print_key && !i_print_lock |-> ##2 o_busy; endproperty
   a_key: assert property (p_key) else $error("print key ignored");
   property p_lock; i_print_key && i_print_lock && !i_ctl_event && !i_cts_trigger
      && !i_interval_on && !o_busy |=> !o_busy; endproperty
   a_lock: assert property (p_lock) else $error("locked key printed");
   property p_ctl; i_ctl_event |-> ##2 o_busy; endproperty
   a_ctl: assert property (p_ctl) else $error("control event ignored");
   property p_start; $fell(o_txd) |-> !o_txd [*8]; endproperty
   a_start: assert property (p_start) else $error("start bit length wrong");
   property p_idle; !o_busy |-> o_txd; endproperty
   a_idle: assert property (p_idle) else $error("line not at stop level when idle");
   property p_init; o_modem_init |-> $past(i_modem_mode) == 2'h3; endproperty
   a_init: assert property (p_init) else $error("modem reset outside its mode");
   property p_pass; o_modem_ready |-> $past(i_modem_mode) == 2'h2; endproperty
   a_pass: assert property (p_pass) else $error("modem routed outside pass mode");
   property p_rx; o_rx_valid |-> i_port_mode == 2'h1 || i_port_mode == 2'h2; endproperty
   a_rx: assert property (p_rx) else $error("receive while receiver off");
endmodule : fsp_top_asserts
bind fsp_top fsp_top_asserts fsp_top_asserts_i (.*);

// ===== fsp_printer.sv
// Printer model: decodes eight-bit frames and can answer with one byte.
// Assumes a bit time of DIV clocks.
module fsp_printer #(parameter int DIV = 8) (
   input  wire logic i_clock,
   input  wire logic i_txd,
   output logic      o_rxd
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] got[$];  // Bytes received, in order.
   logic [7:0] b;       // Byte being assembled.
   initial o_rxd = 1'b1;  // Line idles at mark.
   // Sample each data bit in its middle, LSB first.
   always begin
      @(negedge i_txd);
      repeat (DIV / 2) @(posedge i_clock);
      for (int k = 0; k < 8; k++) begin
         repeat (DIV) @(posedge i_clock);
         b[k] = i_txd;
      end
      got.push_back(b);
      repeat (DIV) @(posedge i_clock);
   end
   // Send one frame back, then rest at mark.
   task automatic send(input logic [7:0] c);
      logic [9:0] f;
      f = {1'b1, c, 1'b0};
      for (int k = 0; k < 10; k++) begin
         o_rxd = f[k];
         repeat (DIV) @(posedge i_clock);
      end
   endtask : send
endmodule : fsp_printer

// ===== fsp_top_bench.sv
// Self-checking bench for the print port, with a printer model on the line.
// Assumes CLK_HZ of 76800 so 9600 baud is eight clocks a bit.
module fsp_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clock = 0, i_sys_rst = 1, i_cfg_wr = 0, i_load_defaults = 0, i_two_stop = 0;
   logic i_seven_bits = 0, i_str_wr = 0, i_wait_en = 0, i_print_key = 0, i_print_lock = 0;
   logic i_ctl_event = 0, i_cts_trigger = 0, i_settled_only = 0, i_in_motion = 0;
   logic i_interval_on = 0, i_modem_valid = 0, i_rxd, i_cts = 1;
   logic [1:0] i_parity = '0, i_port_mode = '0, i_flow = '0, i_modem_mode = '0;
   logic [2:0] i_baud_sel = 3'h5, i_prefix_len = '0, i_suffix_len = 3'h1;
   logic [7:0] i_str_addr = '0, i_str_char = '0, i_wait_char = '0, i_modem_byte = '0, o_rx_data;
   logic [14:0] i_interval_sec = '0;
   logic [31:0] i_prefix_chars = '0, i_suffix_chars = 32'h0A;
   logic [63:0] i_weight_chars = '0;
   logic o_txd, o_rts, o_rx_valid, o_rx_error, o_modem_ready, o_modem_on, o_modem_init, o_busy;
   int n_mismatch = 0, check_count = 0, cyc = 0, n, n_rx = 0;
   string w = "";
   always #20 i_clock = ~i_clock;
   fsp_top #(.CLK_HZ(76800)) fsp_top_i (.*);
   fsp_printer fsp_printer_i (.i_clock(i_clock), .i_txd(o_txd), .o_rxd(i_rxd));
   task automatic tick; @(posedge i_clock); #1; endtask : tick
   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s exp %0h got %0h", s, e, g);
      end
   endtask : chk
   // Wait for the port to go idle, then compare everything printed.
   task automatic expect_str(string s);
      int k;
      k = 0;
      while ((o_busy !== 1'b0 || k < 4) && k < 4000) begin tick; k++; end
      chk("idle", 0, o_busy);
      repeat (20) tick;
      chk("count", s.len(), fsp_printer_i.got.size());
      for (k = 0; k < s.len(); k++) chk("byte", s[k], fsp_printer_i.got[k]);
      fsp_printer_i.got.delete();
   endtask : expect_str
   task automatic wstr(string s);
      for (int k = 0; k < s.len(); k++) begin
         i_str_wr = 1; i_str_addr = k; i_str_char = s[k]; tick;
      end
      i_str_wr = 0;
   endtask : wstr
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   always @(posedge i_clock) if (++cyc == 40000) begin n_mismatch++; report_and_stop; end
   // Counts clean received frames; a parity or stop fault is left out of the count.
   always @(posedge i_clock) if (o_rx_valid === 1'b1 && o_rx_error === 1'b0) n_rx++;
   initial begin
      n = $urandom(32'hE9CE686C);
      for (int k = 7; k >= 0; k--) begin
         i_weight_chars[8*k+:8] = 8'h30 + 8'($urandom % 10);
         w = {w, string'(i_weight_chars[8*k+:8])};
      end
      repeat (20) tick;
      i_sys_rst = 0;
      i_print_key = 1; tick; i_print_key = 0;
      expect_str({w, "\n"});
      i_print_lock = 1; i_print_key = 1; tick; i_print_key = 0;
      expect_str("");
      i_print_lock = 0; i_prefix_len = 3'h1; i_prefix_chars = 32'h50;
      i_suffix_len = 3'h2; i_suffix_chars = 32'h5958;
      i_cfg_wr = 1; tick; i_cfg_wr = 0;
      wstr("@@A@EB\377C");
      i_settled_only = 1; i_in_motion = 1; i_ctl_event = 1; tick; i_ctl_event = 0;
      repeat (50) tick;
      chk("held", 0, fsp_printer_i.got.size());
      i_in_motion = 0;
      expect_str("P@AXYPB");
      i_port_mode = 2'h1; i_wait_en = 1; i_wait_char = 8'h4B;
      i_print_key = 1; tick; i_print_key = 0;
      for (int k = 0; k < 3000 && fsp_printer_i.got.size() < 5; k++) tick;
      repeat (100) tick;
      chk("paused", 5, fsp_printer_i.got.size());
      fsp_printer_i.send(8'h4B);
      chk("rx_data", 8'h4B, o_rx_data);
      chk("rx_count", 1, n_rx);
      expect_str("P@AXYPB");
      i_wait_en = 0;
      i_cts_trigger = 1;
      i_cts = 0;
      tick;
      i_cts = 1;
      tick;
      i_cts_trigger = 0;
      expect_str("P@AXYPB");
      i_modem_byte = 8'($urandom);
      for (int m = 0; m < 4; m++) begin
         i_modem_mode = m;
         i_modem_valid = 1;
         tick;
         chk("mdm_init", m == 3, o_modem_init);
         chk("mdm_on", m != 1, o_modem_on);
         tick;
         chk("mdm_ready", m == 2, o_modem_ready);
         repeat (28) tick;
      end
      i_modem_valid = 0;
      repeat (1500) tick;
      chk("pass", i_modem_byte, fsp_printer_i.got[0]);
      chk("rts", 1, o_rts);
      report_and_stop;
   end
endmodule : fsp_top_bench
